// ==== hw/fsp_defines.svh ====
// Constants for the flash self-programming sequencer
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
// Control register bit positions
`define FSP_B_ENABLE 0
`define FSP_B_PGERS 1
`define FSP_B_PGWRT 2
`define FSP_B_BLB 3
`define FSP_B_RWWRE 4
`define FSP_B_SIG 5
`define FSP_B_BUSY 6
// Accepted command patterns, low six bits
`define FSP_CMD_LOAD 6'h01
`define FSP_CMD_ERASE 6'h03
`define FSP_CMD_WRITE 6'h05
`define FSP_CMD_LOCK 6'h09
`define FSP_CMD_REEN 6'h11
`define FSP_CMD_SIG 6'h21
// Window lengths in cycles
`define FSP_SPM_WIN 3'h4
`define FSP_LD_WIN 3'h3
// Programming time
`define FSP_CLK_NS 20
`define FSP_PROG_MIN_NS 3700000
`define FSP_PROG_MAX_NS 4500000
`define FSP_PROG_CYCLES ((`FSP_PROG_MIN_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
// Read-while-write section limit, byte address
`define FSP_RWW_LIMIT 16'h3000
// Reset values
`define FSP_LOCK_RESET 8'hFF
// Controller register offsets
`define FSP_H_CTRL 3'h0
`define FSP_H_SPM 3'h1
`define FSP_H_LD 3'h2
`define FSP_H_ZL 3'h3
`define FSP_H_ZH 3'h4
`define FSP_H_DLO 3'h5
`define FSP_H_DHI 3'h6
`define FSP_H_STAT 3'h7
`endif

// ==== hw/fsp_pkg.sv ====
// Types for the flash self-programming sequencer
`default_nettype none
package fsp_pkg;
   typedef enum logic [1:0] {
      FSP_OP_IDLE = 2'b00,
      FSP_OP_ERASE = 2'b01,
      FSP_OP_WRITE = 2'b10,
      FSP_OP_LOCK = 2'b11
   } fsp_op_e;
   typedef enum logic [1:0] {
      FSP_RD_FLASH = 2'b00,
      FSP_RD_BLOCK = 2'b01,
      FSP_RD_FUSE = 2'b10,
      FSP_RD_SIG = 2'b11
   } fsp_rd_e;
endpackage : fsp_pkg
`default_nettype wire

// ==== hw/fsp_link_if.sv ====
// Link between CPU end and flash sequencer
`default_nettype none
interface fsp_link_if;
   logic ctrl_wr;
   logic [7:0] ctrl_wdata;
   logic spm_exec;
   logic ld_exec;
   logic [15:0] z_ptr;
   logic [7:0] dlo_data;
   logic [7:0] dhi_data;
   logic [7:0] ctrl_rdata;
   logic [7:0] ld_data;
   logic ld_valid;
   logic ee_busy;
   modport dev (
      input ctrl_wr, ctrl_wdata, spm_exec, ld_exec, z_ptr, dlo_data, dhi_data,
      output ctrl_rdata, ld_data, ld_valid, ee_busy
   );
   modport cpu (
      output ctrl_wr, ctrl_wdata, spm_exec, ld_exec, z_ptr, dlo_data, dhi_data,
      input ctrl_rdata, ld_data, ld_valid, ee_busy
   );
endinterface : fsp_link_if
`default_nettype wire

// ==== hw/fsp_cpu_end.sv ====
// CPU end: command registers driving the sequencer link
`default_nettype none
`include "fsp_defines.svh"
module fsp_cpu_end
   import fsp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Command port
   input wire logic [2:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   output logic [7:0] cmd_rdata,
   // Sequencer link
   fsp_link_if.cpu link
);
   logic [7:0] ld_last;
   logic ctrl_refused;
   logic ld_refused;
   logic ld_done;
   wire wr_ctrl = cmd_wr && cmd_addr == `FSP_H_CTRL;
   wire wr_ld = cmd_wr && cmd_addr == `FSP_H_LD;
   wire rd_stat = cmd_rd && cmd_addr == `FSP_H_STAT;
   wire ctrl_ok = !link.ee_busy;
   wire in_rww = link.z_ptr < `FSP_RWW_LIMIT;
   wire ld_ok = !(link.ctrl_rdata[`FSP_B_BUSY] && in_rww);
   wire [7:0] stat = {4'h0, ld_done, ld_refused, ctrl_refused, link.ee_busy};
   logic [7:0] next_rdata;

   always_comb begin
      case (cmd_addr)
         `FSP_H_CTRL: next_rdata = link.ctrl_rdata;
         `FSP_H_LD: next_rdata = ld_last;
         `FSP_H_ZL: next_rdata = link.z_ptr[7:0];
         `FSP_H_ZH: next_rdata = link.z_ptr[15:8];
         `FSP_H_DLO: next_rdata = link.dlo_data;
         `FSP_H_DHI: next_rdata = link.dhi_data;
         `FSP_H_STAT: next_rdata = stat;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         link.ctrl_wr <= 1'b0;
         link.ctrl_wdata <= 8'h00;
         link.spm_exec <= 1'b0;
         link.ld_exec <= 1'b0;
      end else begin
         link.ctrl_wr <= wr_ctrl && ctrl_ok;
         link.spm_exec <= cmd_wr && cmd_addr == `FSP_H_SPM;
         link.ld_exec <= wr_ld && ld_ok;
         if (wr_ctrl)
            link.ctrl_wdata <= cmd_wdata;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         link.z_ptr <= 16'h0000;
         link.dlo_data <= 8'h00;
         link.dhi_data <= 8'h00;
      end else if (cmd_wr) begin
         if (cmd_addr == `FSP_H_ZL)
            link.z_ptr[7:0] <= cmd_wdata;
         if (cmd_addr == `FSP_H_ZH)
            link.z_ptr[15:8] <= cmd_wdata;
         if (cmd_addr == `FSP_H_DLO)
            link.dlo_data <= cmd_wdata;
         if (cmd_addr == `FSP_H_DHI)
            link.dhi_data <= cmd_wdata;
      end
   end

   // Sticky status, set beats clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_refused <= 1'b0;
         ld_refused <= 1'b0;
         ld_done <= 1'b0;
         ld_last <= 8'h00;
         cmd_rdata <= 8'h00;
      end else begin
         ctrl_refused <= (wr_ctrl && !ctrl_ok) || (ctrl_refused && !rd_stat);
         ld_refused <= (wr_ld && !ld_ok) || (ld_refused && !rd_stat);
         ld_done <= link.ld_valid || (ld_done && !rd_stat);
         if (link.ld_valid)
            ld_last <= link.ld_data;
         cmd_rdata <= cmd_rd ? next_rdata : 8'h00;
      end
   end
endmodule : fsp_cpu_end
`default_nettype wire

// ==== hw/fsp_dev_end.sv ====
// Device end: flash self-programming sequencer
`default_nettype none
`include "fsp_defines.svh"
module fsp_dev_end
   import fsp_pkg::*;
#(
   parameter int PROG_CYCLES = `FSP_PROG_CYCLES,
   parameter int CNT_W = 18,
   parameter logic [15:0] RWW_LIMIT = `FSP_RWW_LIMIT,
   // Arbitrary identification values
   parameter logic [7:0] SIG_ID0 = 8'h5A,
   parameter logic [7:0] SIG_ID1 = 8'h3C,
   parameter logic [7:0] SIG_ID2 = 8'hA5
) (
   // Clock and resets
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic por_n,
   // Sequencer link
   fsp_link_if.dev link,
   // Neighbour status and nonvolatile bytes
   input wire logic eeprom_write_busy,
   input wire logic [7:0] flash_rdata,
   input wire logic [7:0] fuse_low,
   input wire logic [7:0] fuse_high,
   input wire logic [7:0] fuse_ext,
   input wire logic [7:0] osc_cal,
   // Flash array commands
   output logic erase_go,
   output logic write_go,
   output logic load_go,
   output logic buffer_clear,
   output logic [15:0] flash_addr,
   output logic [15:0] load_word,
   output logic [7:0] lock_bits
);
   if (PROG_CYCLES < 1 || CNT_W > 31 || PROG_CYCLES >= (1 << CNT_W)) begin : g_bad_cnt
      $error("fsp_dev_end: PROG_CYCLES does not fit CNT_W");
   end

   // Command bits, system reset
   logic sig;
   logic rwwre;
   logic blb;
   logic pgwrt;
   logic pgers;
   logic prog_en;
   logic [2:0] win;
   // Operation state, power-on reset only
   fsp_op_e op;
   logic [CNT_W-1:0] cnt;
   logic rww_busy;
   logic [3:0] lock_mask;
   // Read pipeline
   logic rd_q;
   fsp_rd_e kind_q;

   wire [5:0] wd = link.ctrl_wdata[5:0];
   wire op_busy = op != FSP_OP_IDLE;
   wire pat_ok = wd == `FSP_CMD_LOAD || wd == `FSP_CMD_ERASE || wd == `FSP_CMD_WRITE ||
      wd == `FSP_CMD_LOCK || wd == `FSP_CMD_REEN || wd == `FSP_CMD_SIG;
   wire acc_wr = link.ctrl_wr && pat_ok && !eeprom_write_busy && !op_busy;
   wire spm_win = win != 3'h0 && prog_en;
   wire ld_win = win > (`FSP_SPM_WIN - `FSP_LD_WIN) && prog_en && (blb || sig);
   wire spm_hit = link.spm_exec && spm_win;
   wire spm_ok = spm_hit && !eeprom_write_busy;
   wire ld_hit = link.ld_exec && ld_win;
   wire sig_expire = sig && win == (`FSP_SPM_WIN - `FSP_LD_WIN + 3'h1) && !ld_hit;
   wire cmd_end = spm_hit || ld_hit || win == 3'h1 || sig_expire;
   wire start_op = spm_ok && (pgers || pgwrt || blb);
   wire reen = spm_ok && rwwre;
   wire done = op_busy && cnt == '0;
   wire in_rww = link.z_ptr < RWW_LIMIT;
   wire blocked = rww_busy && in_rww;
   fsp_rd_e next_kind;
   fsp_op_e next_op;
   logic [7:0] next_data;
   wire [7:0] ctrl_view = {1'b0, rww_busy, sig, rwwre, blb,
      pgwrt || op == FSP_OP_WRITE, pgers || op == FSP_OP_ERASE,
      prog_en || op_busy};

   always_comb begin
      if (ld_hit && eeprom_write_busy)
         next_kind = FSP_RD_BLOCK;
      else if (ld_hit && sig)
         next_kind = FSP_RD_SIG;
      else if (ld_hit)
         next_kind = FSP_RD_FUSE;
      else if (blocked)
         next_kind = FSP_RD_BLOCK;
      else
         next_kind = FSP_RD_FLASH;
   end

   always_comb begin
      if (!start_op)
         next_op = FSP_OP_IDLE;
      else if (pgers)
         next_op = FSP_OP_ERASE;
      else if (pgwrt)
         next_op = FSP_OP_WRITE;
      else
         next_op = FSP_OP_LOCK;
   end

   // Answer selection, programmed bits read zero
   always_comb begin
      case (kind_q)
         FSP_RD_FLASH: next_data = flash_rdata;
         FSP_RD_BLOCK: next_data = 8'hFF;
         FSP_RD_FUSE: begin
            case (flash_addr[1:0])
               2'h0: next_data = fuse_low;
               2'h1: next_data = lock_bits;
               2'h2: next_data = fuse_ext;
               default: next_data = fuse_high;
            endcase
         end
         default: begin
            if (flash_addr[15:3] != 13'h0000)
               next_data = 8'hFF;
            else begin
               case (flash_addr[2:0])
                  3'h0: next_data = SIG_ID0;
                  3'h1: next_data = osc_cal;
                  3'h2: next_data = SIG_ID1;
                  3'h4: next_data = SIG_ID2;
                  default: next_data = 8'hFF;
               endcase
            end
         end
      endcase
   end

   // Control register and timed window
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {sig, rwwre, blb, pgwrt, pgers, prog_en} <= 6'h00;
         win <= 3'h0;
      end else if (acc_wr) begin
         {sig, rwwre, blb, pgwrt, pgers, prog_en} <= wd;
         win <= `FSP_SPM_WIN;
      end else if (cmd_end) begin
         {sig, rwwre, blb, pgwrt, pgers, prog_en} <= 6'h00;
         win <= 3'h0;
      end else if (win != 3'h0) begin
         win <= win - 3'h1;
      end
   end

   // Timed operation survives system reset
   always_ff @(posedge mclk or negedge por_n) begin
      if (!por_n) begin
         op <= FSP_OP_IDLE;
         cnt <= '0;
         lock_mask <= 4'hF;
      end else if (start_op) begin
         op <= next_op;
         cnt <= CNT_W'(PROG_CYCLES - 1);
         lock_mask <= link.dlo_data[5:2];
      end else if (done) begin
         op <= FSP_OP_IDLE;
      end else if (op_busy) begin
         cnt <= cnt - CNT_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge por_n) begin
      if (!por_n) begin
         rww_busy <= 1'b0;
         lock_bits <= `FSP_LOCK_RESET;
      end else begin
         if (start_op && (pgers || pgwrt))
            rww_busy <= 1'b1;
         else if (reen)
            rww_busy <= 1'b0;
         if (done && op == FSP_OP_LOCK)
            lock_bits[5:2] <= lock_bits[5:2] & lock_mask;
      end
   end

   // Flash array strobes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         erase_go <= 1'b0;
         write_go <= 1'b0;
         load_go <= 1'b0;
         buffer_clear <= 1'b0;
         load_word <= 16'h0000;
      end else begin
         erase_go <= start_op && pgers;
         write_go <= start_op && pgwrt;
         load_go <= spm_ok && wd_is_load(pgers, pgwrt, blb, rwwre);
         buffer_clear <= reen;
         if (spm_ok)
            load_word <= {link.dhi_data, link.dlo_data};
      end
   end

   // Read path; lock writes leave rww_busy unchanged
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rd_q <= 1'b0;
         kind_q <= FSP_RD_FLASH;
         flash_addr <= 16'h0000;
         link.ld_data <= 8'h00;
         link.ld_valid <= 1'b0;
         link.ctrl_rdata <= 8'h00;
         link.ee_busy <= 1'b0;
      end else begin
         rd_q <= link.ld_exec;
         if (link.ld_exec || spm_hit) begin
            kind_q <= next_kind;
            flash_addr <= link.z_ptr;
         end
         link.ld_valid <= rd_q;
         if (rd_q)
            link.ld_data <= next_data;
         link.ctrl_rdata <= ctrl_view;
         link.ee_busy <= eeprom_write_busy;
      end
   end

   function automatic logic wd_is_load(input logic e, input logic w, input logic b, input logic r);
      wd_is_load = !(e || w || b || r);
   endfunction : wd_is_load
endmodule : fsp_dev_end
`default_nettype wire

// ==== verification/fsp_props.sv ====
// Link checker for the flash sequencer pair
`default_nettype none
module fsp_props #(
   parameter int PROG_CYCLES = 20
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Link signals
   input wire logic ctrl_wr,
   input wire logic ld_exec,
   input wire logic [15:0] z_ptr,
   input wire logic [7:0] ctrl_rdata,
   input wire logic [7:0] ld_data,
   input wire logic ld_valid,
   input wire logic ee_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic [7:0] op_cnt;
   wire op_on = ctrl_rdata[1] | ctrl_rdata[2];
   // Length of the current erase or write phase
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         op_cnt <= 8'h00;
      end else begin
         op_cnt <= op_on ? op_cnt + 8'h01 : 8'h00;
      end
   end
   a_load_answer: assert property (ld_exec |-> ##2 ld_valid)
      else $error("load answer missing");
   a_valid_cause: assert property (ld_valid |-> $past(ld_exec, 2))
      else $error("load answer without request");
   a_busy_enable: assert property ($rose(ctrl_rdata[6]) |-> ##1 ctrl_rdata[0] [*8])
      else $error("enable dropped while busy");
   a_op_long: assert property ($fell(op_on) && ctrl_rdata[6] |-> op_cnt >= PROG_CYCLES - 2)
      else $error("operation too short");
   a_op_short: assert property (op_on |-> op_cnt <= PROG_CYCLES + 6)
      else $error("operation too long");
   a_ctrl_refuse: assert property (ctrl_wr && !ctrl_rdata[0] ##1 ee_busy |=> !ctrl_rdata[0] [*3])
      else $error("control write taken while eeprom busy");
   a_sig_close: assert property ($rose(ctrl_rdata[5]) |-> ##[1:3] !ctrl_rdata[5])
      else $error("signature window stayed open");
   a_lock_close: assert property ($rose(ctrl_rdata[3]) |-> ##[1:4] !ctrl_rdata[3])
      else $error("lock window stayed open");
   a_rww_block: assert property (ld_exec |-> !(ctrl_rdata[6] && z_ptr < 16'h3000))
      else $error("blocked section read");
   c_erase: cover property ($rose(ctrl_rdata[6]));
   c_special: cover property (ld_valid && ld_data != 8'hFF);
   c_refuse: cover property (ctrl_wr ##1 ee_busy);
endmodule : fsp_props
`default_nettype wire

// ==== verification/fsp_tb_top.sv ====
// Testbench for the flash sequencer pair
`default_nettype none
`include "fsp_defines.svh"
module fsp_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PC = 20;
   localparam logic [7:0] FZ [4] = '{8'h6E, 8'hFF, 8'hF4, 8'hD9};
   localparam logic [15:0] SZ [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004};
   localparam logic [7:0] SE [4] = '{8'h12, 8'h8B, 8'h34, 8'h56};
   localparam logic [7:0] OPC [2] = '{8'h03, 8'h05};
   localparam logic [7:0] OPV [2] = '{8'h43, 8'h45};
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic por_n = 1'b0;
   logic [2:0] cmd_addr = 3'h0;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_wr = 1'b0;
   logic cmd_rd = 1'b0;
   logic ee_wr = 1'b0;
   logic [7:0] cmd_rdata;
   logic [15:0] flash_addr;
   logic [7:0] lock_bits;
   logic [7:0] v;
   logic erase_go;
   logic write_go;
   logic load_go;
   logic buffer_clear;
   logic [15:0] load_word;
   int n_erase = 0;
   int n_write = 0;
   int n_load = 0;
   int n_clear = 0;
   // Strobe counters
   always @(posedge mclk) begin
      if (erase_go) n_erase++;
      if (write_go) n_write++;
      if (load_go) n_load++;
      if (buffer_clear) n_clear++;
   end
   int n_fail = 0;
   int checked = 0;
   wire logic [7:0] flash_rdata = flash_addr[7:0] ^ 8'hC3;
   always #10 mclk = ~mclk;
   fsp_link_if i_fsp_link_if ();
   fsp_cpu_end i_fsp_cpu_end (.mclk(mclk), .reset_n(reset_n), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .link(i_fsp_link_if));
   fsp_dev_end #(.PROG_CYCLES(PC), .CNT_W(5), .SIG_ID0(SE[0]), .SIG_ID1(SE[2]), .SIG_ID2(SE[3])) i_fsp_dev_end (
      .mclk(mclk), .reset_n(reset_n), .por_n(por_n), .link(i_fsp_link_if), .eeprom_write_busy(ee_wr),
      .flash_rdata(flash_rdata), .fuse_low(FZ[0]), .fuse_high(FZ[3]), .fuse_ext(FZ[2]), .osc_cal(SE[1]),
      .erase_go(erase_go), .write_go(write_go), .load_go(load_go), .buffer_clear(buffer_clear),
      .flash_addr(flash_addr), .load_word(load_word), .lock_bits(lock_bits));
   fsp_props #(.PROG_CYCLES(PC)) i_fsp_props (.mclk(mclk), .reset_n(reset_n), .ctrl_wr(i_fsp_link_if.ctrl_wr),
      .ld_exec(i_fsp_link_if.ld_exec), .z_ptr(i_fsp_link_if.z_ptr), .ctrl_rdata(i_fsp_link_if.ctrl_rdata),
      .ld_data(i_fsp_link_if.ld_data), .ld_valid(i_fsp_link_if.ld_valid), .ee_busy(i_fsp_link_if.ee_busy));
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge mclk);
      cmd_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge mclk);
      cmd_rd <= 1'b0;
      #1 d = cmd_rdata;
   endtask : rd
   // Pointer, optional window command, load, then read back the loaded byte
   task automatic rdl(input logic [7:0] c, input logic [15:0] z, input logic [7:0] e);
      wr(`FSP_H_ZL, z[7:0]);
      wr(`FSP_H_ZH, z[15:8]);
      if (c != 8'h00) wr(`FSP_H_CTRL, c);
      wr(`FSP_H_LD, 8'h00);
      repeat (3) @(posedge mclk);
      rd(`FSP_H_LD, v);
      chk(v, e);
   endtask : rdl
   task automatic lock_set(input logic [7:0] lo);
      wr(`FSP_H_ZL, 8'h01);
      wr(`FSP_H_ZH, 8'h00);
      wr(`FSP_H_DLO, lo);
      wr(`FSP_H_CTRL, 8'h09);
      wr(`FSP_H_SPM, 8'h00);
   endtask : lock_set
   initial begin
      repeat (5000) @(posedge mclk);
      n_fail++;
      end_sim;
   end
   initial begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      por_n <= 1'b1;
      rd(`FSP_H_CTRL, v);
      chk(v, 8'h00);
      chk(lock_bits, 8'hFF);
      for (int i = 0; i < 4; i++) rdl(8'h09, 16'(i), FZ[i]);
      for (int i = 0; i < 4; i++) rdl(8'h21, SZ[i], SE[i]);
      rdl(8'h00, 16'h0004, 8'hC7);
      for (int i = 0; i < 2; i++) begin
         wr(`FSP_H_CTRL, OPC[i] + 8'h06);
         repeat (6) @(posedge mclk);
         rdl(8'h00, 16'h0001, 8'hC2);
      end
      wr(`FSP_H_CTRL, 8'h09);
      ee_wr <= 1'b1;
      @(posedge mclk);
      rd(`FSP_H_CTRL, v);
      chk(v, 8'h00);
      rd(`FSP_H_STAT, v);
      wr(`FSP_H_CTRL, 8'h09);
      rd(`FSP_H_STAT, v);
      chk(v, 8'h03);
      ee_wr <= 1'b0;
      lock_set(8'hE7);
      repeat (3) @(posedge mclk);
      rd(`FSP_H_CTRL, v);
      chk(v, 8'h01);
      rdl(8'h00, 16'h0010, 8'hD3);
      repeat (30) @(posedge mclk);
      chk(lock_bits, 8'hE7);
      rdl(8'h09, 16'h0001, 8'hE7);
      lock_set(8'hDF);
      repeat (4) @(posedge mclk);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (30) @(posedge mclk);
      chk(lock_bits, 8'hC7);
      for (int i = 0; i < 2; i++) begin
         wr(`FSP_H_CTRL, OPC[i]);
         wr(`FSP_H_SPM, 8'h00);
         repeat (3) @(posedge mclk);
         rd(`FSP_H_CTRL, v);
         chk(v, OPV[i]);
         rd(`FSP_H_STAT, v);
         wr(`FSP_H_ZH, 8'h01);
         wr(`FSP_H_LD, 8'h00);
         rd(`FSP_H_STAT, v);
         chk(v & 8'h04, 8'h04);
         rdl(8'h00, 16'h3100, 8'hC3);
         repeat (30) @(posedge mclk);
         rd(`FSP_H_CTRL, v);
         chk(v, 8'h40);
         wr(`FSP_H_CTRL, 8'h11);
         wr(`FSP_H_SPM, 8'h00);
         repeat (3) @(posedge mclk);
         rd(`FSP_H_CTRL, v);
         chk(v, 8'h00);
      end
      wr(`FSP_H_DLO, 8'h34);
      wr(`FSP_H_DHI, 8'h12);
      wr(`FSP_H_CTRL, 8'h01);
      wr(`FSP_H_SPM, 8'h00);
      repeat (3) @(posedge mclk);
      chk(load_word[7:0], 8'h34);
      chk(load_word[15:8], 8'h12);
      chk(8'(n_load), 8'h01);
      chk(8'(n_erase), 8'h01);
      chk(8'(n_write), 8'h01);
      chk(8'(n_clear), 8'h02);
      rdl(8'h00, 16'h0100, 8'hC3);
      end_sim;
   end
endmodule : fsp_tb_top
`default_nettype wire
